// ---- common/dmaad_pkg.sv ----
// ************************************************************
// dma acknowledge and destination mode constants
// ************************************************************
package dmaad_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CHANS = 4;
  localparam int ACK_CHANS = 2;
  localparam int FIFO_DEPTH = 32;
  localparam int UNIT_W = 6;

  // register pages, word index in addr[3:2]
  localparam logic [3:0] PAGE_CTRL = 4'h0;
  localparam logic [3:0] PAGE_DEST = 4'h1;
  localparam logic [7:0] STAT_OFF = 8'h20;

  // channel_control field positions
  localparam int ACK_CYCLE_BIT = 17;
  localparam int ACK_POL_BIT = 16;
  localparam int DEST_MODE_HI = 15;
  localparam int DEST_MODE_LO = 14;

  // status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CHAN_LSB = 1;
  localparam int STAT_CHAN_MSB = 2;

  // reset values
  localparam logic ACK_CYCLE_RST = 1'b0;
  localparam logic ACK_POL_RST = 1'b0;
  localparam logic [31:0] DEST_ADDR_RST = 32'h0000_0000;

  // unit word layout: {chan, single, dev2mem, size}
  localparam int U_SIZE_LSB = 0;
  localparam int U_SIZE_MSB = 1;
  localparam int U_DEV2MEM = 2;
  localparam int U_SINGLE = 3;
  localparam int U_CHAN_LSB = 4;
  localparam int U_CHAN_MSB = 5;

  typedef enum logic [1:0] {
    DMAAD_DM_FIXED = 2'b00,
    DMAAD_DM_INC = 2'b01,
    DMAAD_DM_DEC = 2'b10,
    DMAAD_DM_BAD = 2'b11
  } dmaad_dmode_t;

  typedef enum logic [1:0] {
    DMAAD_SZ_8 = 2'b00,
    DMAAD_SZ_16 = 2'b01,
    DMAAD_SZ_32 = 2'b10
  } dmaad_size_t;

  localparam logic [31:0] STEP_8 = 32'h0000_0001;
  localparam logic [31:0] STEP_16 = 32'h0000_0002;
  localparam logic [31:0] STEP_32 = 32'h0000_0004;

  typedef enum logic [2:0] {
    DMAAD_ST_IDLE = 3'b000,
    DMAAD_ST_READ = 3'b001,
    DMAAD_ST_WRITE = 3'b010,
    DMAAD_ST_SINGLE = 3'b011,
    DMAAD_ST_DONE = 3'b100
  } dmaad_state_t;
endpackage

// ---- verilog/dmaad_step.sv ----
`timescale 1ns/100ps
// ************************************************************
// destination address step for one channel
// ************************************************************
module dmaad_step #(
  parameter int AW = 32
) (
  input wire logic [AW-1:0] cur_addr,
  input wire logic [1:0] mode,
  input wire logic [1:0] size,
  output logic [AW-1:0] next_addr
);
  logic [AW-1:0] step;

  always_comb begin
    case (size)
      dmaad_pkg::DMAAD_SZ_8: step = AW'(dmaad_pkg::STEP_8);
      dmaad_pkg::DMAAD_SZ_16: step = AW'(dmaad_pkg::STEP_16);
      default: step = AW'(dmaad_pkg::STEP_32);
    endcase
  end

  always_comb begin
    case (mode)
      dmaad_pkg::DMAAD_DM_INC: next_addr = cur_addr + step;
      dmaad_pkg::DMAAD_DM_DEC: next_addr = cur_addr - step;
      // the prohibited code behaves as fixed rather than walking off
      default: next_addr = cur_addr;
    endcase
  end
endmodule // dmaad_step

// ---- verilog/dmaad_fifo.sv ----
`timescale 1ns/100ps
// ************************************************************
// transfer unit queue
// ************************************************************
module dmaad_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] cnt_r;
  logic [PW:0] cnt_nxt;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      // registered ready: full is known a cycle ahead from the count
      in_ready <= (cnt_nxt != (PW + 1)'(DEPTH));
    end
  end
endmodule // dmaad_fifo

// ---- verilog/dmaad_top.sv ----
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
// Operation
// - dual mode: ack on read or write
// - single mode: ack every transfer always
// - ack cycle bit only on channels 0,1
// - polarity bit: 0 high, 1 low
// - polarity bit only on channels 0,1
// - mode 00 fixed; 11 prohibited
// - mode 01 increments by size
// - mode 10 decrements by size
// - single device-to-memory ignores destination mode
// - single memory-to-device ignores destination register
module dmaad_top #(
  parameter int AW = 32,
  parameter int DEPTH = dmaad_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [dmaad_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dmaad_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dmaad_pkg::DATA_W-1:0] reg_rdata,
  input wire logic unit_valid,
  output logic unit_ready,
  input wire logic [1:0] unit_chan,
  input wire logic unit_single,
  input wire logic unit_dev2mem,
  input wire logic [1:0] unit_size,
  output logic rd_cycle,
  output logic wr_cycle,
  output logic single_cycle,
  output logic [AW-1:0] dest_addr_out,
  output logic [dmaad_pkg::ACK_CHANS-1:0] dma_ack_out,
  output logic unit_done
);
  // ************************************************************
  // declarations
  // ************************************************************
  localparam int NCH = dmaad_pkg::CHANS;
  localparam int NACK = dmaad_pkg::ACK_CHANS;
  localparam int UW = dmaad_pkg::UNIT_W;

  dmaad_pkg::dmaad_state_t state_r;
  dmaad_pkg::dmaad_state_t state_nxt;
  logic [NACK-1:0] ack_cycle_select_r;
  logic [NACK-1:0] ack_polarity_r;
  logic [1:0] dest_mode_r [NCH];
  logic [AW-1:0] dest_address_reg_r [NCH];
  logic [AW-1:0] step_nxt [NCH];
  logic [UW-1:0] unit_r;
  logic [UW-1:0] unit_nxt;
  logic [UW-1:0] f_data;
  logic f_valid;
  logic f_pop;
  logic [1:0] chan_nxt;
  logic [1:0] cur_chan;
  logic cur_single;
  logic cur_dev2mem;
  logic upd_en;
  logic ack_act;
  logic [dmaad_pkg::DATA_W-1:0] rd_mux;
  logic [1:0] widx;
  logic ctrl_hit;
  logic dest_hit;

  assign widx = reg_addr[3:2];
  assign ctrl_hit = (reg_addr[7:4] == dmaad_pkg::PAGE_CTRL) && (reg_addr[1:0] == 2'b00);
  assign dest_hit = (reg_addr[7:4] == dmaad_pkg::PAGE_DEST) && (reg_addr[1:0] == 2'b00);
  assign cur_chan = unit_r[dmaad_pkg::U_CHAN_MSB:dmaad_pkg::U_CHAN_LSB];
  assign cur_single = unit_r[dmaad_pkg::U_SINGLE];
  assign cur_dev2mem = unit_r[dmaad_pkg::U_DEV2MEM];

  // ************************************************************
  // unit queue; only a full queue back-pressures the source
  // ************************************************************
  dmaad_fifo #(
    .WIDTH(UW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(unit_valid),
    .in_ready(unit_ready),
    .in_data({unit_chan, unit_single, unit_dev2mem, unit_size}),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  assign f_pop = (state_r == dmaad_pkg::DMAAD_ST_IDLE);
  assign unit_nxt = (f_pop && f_valid) ? f_data : unit_r;
  assign chan_nxt = unit_nxt[dmaad_pkg::U_CHAN_MSB:dmaad_pkg::U_CHAN_LSB];

  // ************************************************************
  // per-channel address steppers
  // ************************************************************
  for (genvar c = 0; c < NCH; c++) begin : g_step
    dmaad_step #(
      .AW(AW)
    ) u_step (
      .cur_addr(dest_address_reg_r[c]),
      .mode(dest_mode_r[c]),
      .size(unit_r[dmaad_pkg::U_SIZE_MSB:dmaad_pkg::U_SIZE_LSB]),
      .next_addr(step_nxt[c])
    );
  end

  // ************************************************************
  // transfer sequencer
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dmaad_pkg::DMAAD_ST_IDLE: begin
        if (f_valid) begin
          state_nxt = f_data[dmaad_pkg::U_SINGLE] ? dmaad_pkg::DMAAD_ST_SINGLE
                                                   : dmaad_pkg::DMAAD_ST_READ;
        end
      end
      dmaad_pkg::DMAAD_ST_READ: state_nxt = dmaad_pkg::DMAAD_ST_WRITE;
      dmaad_pkg::DMAAD_ST_WRITE: state_nxt = dmaad_pkg::DMAAD_ST_DONE;
      dmaad_pkg::DMAAD_ST_SINGLE: state_nxt = dmaad_pkg::DMAAD_ST_DONE;
      dmaad_pkg::DMAAD_ST_DONE: state_nxt = dmaad_pkg::DMAAD_ST_IDLE;
      default: state_nxt = dmaad_pkg::DMAAD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= dmaad_pkg::DMAAD_ST_IDLE;
      unit_r <= '0;
    end else begin
      state_r <= state_nxt;
      unit_r <= unit_nxt;
    end
  end

  // ************************************************************
  // acknowledge timing and level
  // ************************************************************
  always_comb begin
    ack_act = 1'b0;
    if (unit_nxt[dmaad_pkg::U_SINGLE]) begin
      ack_act = (state_nxt == dmaad_pkg::DMAAD_ST_SINGLE);
    end else if (chan_nxt < 2'(NACK)) begin
      ack_act = ack_cycle_select_r[chan_nxt[0]]
              ? (state_nxt == dmaad_pkg::DMAAD_ST_WRITE)
              : (state_nxt == dmaad_pkg::DMAAD_ST_READ);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dma_ack_out <= '0;
    end else begin
      for (int c = 0; c < NACK; c++) begin
        dma_ack_out[c] <= (ack_act && (chan_nxt == 2'(c))) ^ ack_polarity_r[c];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_cycle <= 1'b0;
      wr_cycle <= 1'b0;
      single_cycle <= 1'b0;
      unit_done <= 1'b0;
      dest_addr_out <= '0;
    end else begin
      rd_cycle <= (state_nxt == dmaad_pkg::DMAAD_ST_READ);
      wr_cycle <= (state_nxt == dmaad_pkg::DMAAD_ST_WRITE);
      single_cycle <= (state_nxt == dmaad_pkg::DMAAD_ST_SINGLE);
      unit_done <= (state_nxt == dmaad_pkg::DMAAD_ST_DONE);
      if (state_nxt == dmaad_pkg::DMAAD_ST_WRITE ||
          (state_nxt == dmaad_pkg::DMAAD_ST_SINGLE && unit_nxt[dmaad_pkg::U_DEV2MEM])) begin
        dest_addr_out <= dest_address_reg_r[chan_nxt];
      end else begin
        dest_addr_out <= '0;
      end
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  // single units leave the address alone
  assign upd_en = (state_r == dmaad_pkg::DMAAD_ST_DONE) && !cur_single;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_cycle_select_r <= {NACK{dmaad_pkg::ACK_CYCLE_RST}};
      ack_polarity_r <= {NACK{dmaad_pkg::ACK_POL_RST}};
    end else if (reg_wr && ctrl_hit && (widx < 2'(NACK))) begin
      ack_cycle_select_r[widx[0]] <= reg_wdata[dmaad_pkg::ACK_CYCLE_BIT];
      ack_polarity_r[widx[0]] <= reg_wdata[dmaad_pkg::ACK_POL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < NCH; c++) begin
        dest_mode_r[c] <= dmaad_pkg::DMAAD_DM_FIXED;
      end
    end else if (reg_wr && ctrl_hit) begin
      dest_mode_r[widx] <= reg_wdata[dmaad_pkg::DEST_MODE_HI:dmaad_pkg::DEST_MODE_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < NCH; c++) begin
        dest_address_reg_r[c] <= AW'(dmaad_pkg::DEST_ADDR_RST);
      end
    end else begin
      // hardware step wins over a same-cycle write to that channel
      if (reg_wr && dest_hit && !(upd_en && widx == cur_chan)) begin
        dest_address_reg_r[widx] <= AW'(reg_wdata);
      end
      if (upd_en) begin
        dest_address_reg_r[cur_chan] <= step_nxt[cur_chan];
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    if (ctrl_hit) begin
      if (widx < 2'(NACK)) begin
        rd_mux[dmaad_pkg::ACK_CYCLE_BIT] = ack_cycle_select_r[widx[0]];
        rd_mux[dmaad_pkg::ACK_POL_BIT] = ack_polarity_r[widx[0]];
      end
      rd_mux[dmaad_pkg::DEST_MODE_HI:dmaad_pkg::DEST_MODE_LO] = dest_mode_r[widx];
    end else if (dest_hit) begin
      rd_mux = dmaad_pkg::DATA_W'(dest_address_reg_r[widx]);
    end else if (reg_addr == dmaad_pkg::STAT_OFF) begin
      rd_mux[dmaad_pkg::STAT_BUSY_BIT] = (state_r != dmaad_pkg::DMAAD_ST_IDLE);
      rd_mux[dmaad_pkg::STAT_CHAN_MSB:dmaad_pkg::STAT_CHAN_LSB] = cur_chan;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_dual_walk;
    rd_cycle ##1 wr_cycle ##1 unit_done;
  endsequence

  sequence s_single_walk;
    single_cycle ##1 unit_done;
  endsequence

  a_dual_ack_phase: assert property (
    (rd_cycle || wr_cycle) && !cur_single && cur_chan == 2'h0 |->
      dma_ack_out[0] == ((wr_cycle == ack_cycle_select_r[0]) ^ ack_polarity_r[0]))
    else $error("dual ack phase wrong");

  a_dual_order: assert property (
    state_r == dmaad_pkg::DMAAD_ST_IDLE && f_valid && !f_data[dmaad_pkg::U_SINGLE]
      |=> s_dual_walk)
    else $error("dual walk broken");

  a_single_ack_on: assert property (
    single_cycle && cur_chan < 2'(NACK) && !$past(reg_wr) |->
      dma_ack_out[cur_chan[0]] == !ack_polarity_r[cur_chan[0]])
    else $error("single ack missing");

  a_single_order: assert property (
    state_r == dmaad_pkg::DMAAD_ST_IDLE && f_valid && f_data[dmaad_pkg::U_SINGLE]
      |=> s_single_walk)
    else $error("single walk broken");

  a_high_chan_zero: assert property (
    reg_rd && ctrl_hit && widx >= 2'(NACK) |=>
      reg_rdata[dmaad_pkg::ACK_CYCLE_BIT:dmaad_pkg::ACK_POL_BIT] == 2'b00)
    else $error("channel 2/3 ack bits not zero");

  a_ack_idle_level: assert property (
    state_r == dmaad_pkg::DMAAD_ST_DONE && !$past(reg_wr) |->
      dma_ack_out == ack_polarity_r)
    else $error("inactive ack level wrong");

  a_fixed_holds: assert property (
    upd_en && dest_mode_r[cur_chan] == dmaad_pkg::DMAAD_DM_FIXED |=>
      dest_address_reg_r[$past(cur_chan)] == $past(dest_address_reg_r[cur_chan]))
    else $error("fixed destination moved");

  a_inc_step: assert property (
    upd_en && dest_mode_r[cur_chan] == dmaad_pkg::DMAAD_DM_INC &&
      unit_r[dmaad_pkg::U_SIZE_MSB:dmaad_pkg::U_SIZE_LSB] == dmaad_pkg::DMAAD_SZ_16 |=>
      dest_address_reg_r[$past(cur_chan)] ==
        $past(dest_address_reg_r[cur_chan]) + AW'(dmaad_pkg::STEP_16))
    else $error("increment step wrong");

  a_dec_step: assert property (
    upd_en && dest_mode_r[cur_chan] == dmaad_pkg::DMAAD_DM_DEC &&
      unit_r[dmaad_pkg::U_SIZE_MSB:dmaad_pkg::U_SIZE_LSB] == dmaad_pkg::DMAAD_SZ_32 |=>
      dest_address_reg_r[$past(cur_chan)] ==
        $past(dest_address_reg_r[cur_chan]) - AW'(dmaad_pkg::STEP_32))
    else $error("decrement step wrong");

  a_single_in_hold: assert property (
    state_r == dmaad_pkg::DMAAD_ST_DONE && cur_single && cur_dev2mem &&
      !(reg_wr && dest_hit) |=>
      dest_address_reg_r[$past(cur_chan)] == $past(dest_address_reg_r[cur_chan]))
    else $error("single inbound moved address");

  a_single_out_addr: assert property (
    single_cycle && !cur_dev2mem |-> dest_addr_out == '0)
    else $error("address driven to peripheral");

  a_reset_clear: assert property (disable iff (1'b0)
    rst |=> ack_cycle_select_r == '0 && ack_polarity_r == '0 &&
      dest_mode_r[0] == 2'b00 && dest_mode_r[3] == 2'b00)
    else $error("fields not cleared by reset");
endmodule // dmaad_top

// ---- test/dmaad_periph.sv ----
`timescale 1ns/100ps
// ************************************************************
// peripheral side: offers transfer units, counts acknowledges
// ************************************************************
module dmaad_periph (
  input wire logic clk,
  input wire logic unit_ready,
  input wire logic [1:0] dma_ack_out,
  input wire logic [1:0] ack_pol,
  output logic unit_valid,
  output logic [1:0] unit_chan,
  output logic unit_single,
  output logic unit_dev2mem,
  output logic [1:0] unit_size,
  output int ack_pulses
);
  initial begin
    unit_valid = 1'b0;
    unit_chan = 2'h0;
    unit_single = 1'b0;
    unit_dev2mem = 1'b0;
    unit_size = 2'h0;
    ack_pulses = 0;
  end

  // any line away from its idle level is an acknowledge
  always @(posedge clk) begin
    if ((dma_ack_out ^ ack_pol) !== 2'h0) begin
      ack_pulses <= ack_pulses + 1;
    end
  end

  // holds the unit up until it is taken; lim bounds the wait, so a full
  // queue shows as taken below n
  task automatic offer(input logic [1:0] chan, input logic single, input logic dev2mem,
      input logic [1:0] size, input int gap, input int n, input int lim, output int taken);
    int waited;
    taken = 0;
    waited = 0;
    repeat (gap + 1) @(posedge clk);
    unit_valid <= 1'b1;
    unit_chan <= chan;
    unit_single <= single;
    unit_dev2mem <= dev2mem;
    unit_size <= size;
    while (taken < n && waited < lim) begin
      @(posedge clk);
      if (unit_ready === 1'b1) begin
        taken++;
      end
      waited++;
    end
    // released fields show a changed value, not the last one
    unit_valid <= 1'b0;
    unit_chan <= ~chan;
    unit_single <= ~single;
    unit_dev2mem <= ~dev2mem;
    unit_size <= ~size;
  endtask
endmodule // dmaad_periph

// ---- test/dmaad_top_bench.sv ----
`timescale 1ns/100ps
module dmaad_top_bench;
  logic clk;
  logic rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic unit_valid;
  logic unit_ready;
  logic [1:0] unit_chan;
  logic unit_single;
  logic unit_dev2mem;
  logic [1:0] unit_size;
  logic rd_cycle;
  logic wr_cycle;
  logic single_cycle;
  logic [31:0] dest_addr_out;
  logic [1:0] dma_ack_out;
  logic unit_done;
  logic [1:0] ack_pol;
  int ack_pulses;
  int done_count;
  int failures;
  int samples_checked;
  logic [31:0] rv;

  dmaad_top #(.AW(32), .DEPTH(dmaad_pkg::FIFO_DEPTH)) i_dmaad_top (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .unit_valid(unit_valid), .unit_ready(unit_ready),
    .unit_chan(unit_chan), .unit_single(unit_single), .unit_dev2mem(unit_dev2mem),
    .unit_size(unit_size), .rd_cycle(rd_cycle), .wr_cycle(wr_cycle),
    .single_cycle(single_cycle), .dest_addr_out(dest_addr_out),
    .dma_ack_out(dma_ack_out), .unit_done(unit_done));
  dmaad_periph i_dmaad_periph (.clk(clk), .unit_ready(unit_ready), .dma_ack_out(dma_ack_out),
    .ack_pol(ack_pol), .unit_valid(unit_valid), .unit_chan(unit_chan),
    .unit_single(unit_single), .unit_dev2mem(unit_dev2mem), .unit_size(unit_size),
    .ack_pulses(ack_pulses));

  // ************************************************************
  // clock, reset, watchdog
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (unit_done === 1'b1) begin
      done_count <= done_count + 1;
    end
  end

  initial begin
    #(100 * 20000);
    failures++;
    report_and_stop();
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic report_and_stop();
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_val(name, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  function automatic logic [31:0] ctrl_word(input logic ackc, input logic pol,
      input logic [1:0] mode);
    return (32'(ackc) << dmaad_pkg::ACK_CYCLE_BIT) | (32'(pol) << dmaad_pkg::ACK_POL_BIT)
      | (32'(mode) << dmaad_pkg::DEST_MODE_LO);
  endfunction

  function automatic logic [1:0] ack_exp(input int chan, input logic active);
    logic [1:0] v;
    v = ack_pol;
    if (active && chan < 2) begin
      v[chan] = ~v[chan];
    end
    return v;
  endfunction

  task automatic set_chan(input int ch, input logic ackc, input logic pol,
      input logic [1:0] mode, input logic [31:0] dest);
    reg_write(8'(4 * ch), ctrl_word(ackc, pol, mode));
    reg_write(8'h10 + 8'(4 * ch), dest);
    if (ch < 2) begin
      ack_pol[ch] = pol;
    end
    @(posedge clk);
    #1;
    chk_val("idle ack", {30'h0, ack_exp(0, 1'b0)}, {30'h0, dma_ack_out});
  endtask

  task automatic wait_flag(input string name, input int which);
    int n;
    logic hit;
    hit = 1'b0;
    for (n = 0; n < 20 && !hit; n++) begin
      @(posedge clk);
      #1;
      case (which)
        0: hit = (rd_cycle === 1'b1);
        1: hit = (single_cycle === 1'b1);
        default: hit = (unit_done === 1'b1);
      endcase
    end
    chk_bit(name, 1'b1, hit);
  endtask

  // one dual unit: ack in read or write cycle, address used, address after step
  task automatic run_dual(input int ch, input logic ackc, input logic [1:0] size,
      input logic [31:0] dest, input logic [31:0] next);
    int taken;
    i_dmaad_periph.offer(2'(ch), 1'b0, 1'b0, size, 1, 1, 50, taken);
    wait_flag("rd_cycle", 0);
    chk_val("ack read", {30'h0, ack_exp(ch, !ackc)}, {30'h0, dma_ack_out});
    @(posedge clk);
    #1;
    chk_bit("wr_cycle", 1'b1, wr_cycle);
    chk_val("ack write", {30'h0, ack_exp(ch, ackc)}, {30'h0, dma_ack_out});
    chk_val("dest used", dest, dest_addr_out);
    wait_flag("unit_done", 2);
    reg_read(8'h10 + 8'(4 * ch), rv);
    chk_val("dest after", next, rv);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    for (int ch = 0; ch < 4; ch++) begin
      reg_read(8'(4 * ch), rv);
      chk_val("ctrl reset", 32'h0000_0000, rv);
      reg_read(8'h10 + 8'(4 * ch), rv);
      chk_val("dest reset", 32'h0000_0000, rv);
    end
    reg_read(8'h30, rv);
    chk_val("unmapped", 32'h0000_0000, rv);
  endtask

  task automatic t_fields();
    for (int ch = 0; ch < 4; ch++) begin
      // software keeps the ack bits of channels 2,3 at zero
      reg_write(8'(4 * ch), ctrl_word(ch < 2, ch < 2, 2'b10));
    end
    // high channels read first, while channels 0,1 still hold ones
    for (int ch = 3; ch >= 0; ch--) begin
      reg_read(8'(4 * ch), rv);
      chk_val("ctrl field", (ch < 2) ? 32'h0003_8000 : 32'h0000_8000, rv);
      reg_write(8'(4 * ch), 32'h0000_0000);
    end
  endtask

  task automatic t_dual_ack();
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 4; k++) begin
        set_chan(ch, k[0], k[1], 2'b00, 32'h0000_0040);
        run_dual(ch, k[0], 2'b10, 32'h0000_0040, 32'h0000_0040);
      end
    end
  endtask

  task automatic t_steps();
    logic [31:0] steps [3];
    steps = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0004};
    for (int s = 0; s < 3; s++) begin
      set_chan(1, 1'b0, 1'b0, 2'b01, 32'h0000_0100);
      run_dual(1, 1'b0, 2'(s), 32'h0000_0100, 32'h0000_0100 + steps[s]);
      set_chan(1, 1'b0, 1'b0, 2'b10, 32'h0000_0100);
      run_dual(1, 1'b0, 2'(s), 32'h0000_0100, 32'h0000_0100 - steps[s]);
    end
  endtask

  task automatic t_single();
    int taken;
    set_chan(0, 1'b1, 1'b1, 2'b01, 32'h0000_0080);
    for (int d = 0; d < 2; d++) begin
      i_dmaad_periph.offer(2'h0, 1'b1, d[0], 2'b10, 3, 1, 50, taken);
      wait_flag("single_cycle", 1);
      chk_val("ack single", {30'h0, ack_exp(0, 1'b1)}, {30'h0, dma_ack_out});
      chk_val("dest on bus", d ? 32'h0000_0080 : 32'h0000_0000, dest_addr_out);
      wait_flag("unit_done", 2);
      reg_read(8'h10, rv);
      chk_val("dest single", 32'h0000_0080, rv);
    end
  endtask

  // queue fills while the engine works off four cycles a unit
  task automatic t_fill();
    int taken;
    int base;
    int pulses;
    int n;
    set_chan(3, 1'b0, 1'b0, 2'b01, 32'h0000_0000);
    base = done_count;
    pulses = ack_pulses;
    i_dmaad_periph.offer(2'h3, 1'b0, 1'b0, 2'b00, 0, 60, 60, taken);
    chk_bit("queue refused", 1'b1, taken >= dmaad_pkg::FIFO_DEPTH && taken < 60);
    for (n = 0; n < 400 && done_count < base + taken; n++) begin
      @(posedge clk);
    end
    reg_read(8'h1C, rv);
    chk_val("dest drained", 32'(taken), rv);
    reg_read(dmaad_pkg::STAT_OFF, rv);
    // idle, last channel 3 in the channel field
    chk_val("status idle", 32'h0000_0006, rv);
    chk_val("no ack ch3", 32'(pulses), 32'(ack_pulses));
  endtask

  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ack_pol = 2'h0;
    done_count = 0;
    failures = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_dual_ack();
    t_steps();
    t_single();
    t_fill();
    report_and_stop();
  end
endmodule // dmaad_top_bench
